// File: smbsel_pkg.sv
// shared constants for the chip-selected management bus slave and its host
package smbsel_pkg;
   localparam int unsigned CLK_HZ            = 25_000_000;
   localparam logic [6:0]  SLAVE_ADDR        = 7'h56;   // 1010110
   localparam logic [7:0]  ADDR_BYTE_WR      = 8'hAC;
   localparam real         BUF_FREE_US       = 4.7;
   localparam real         HIGH_MAX_US       = 50.0;
   localparam real         TIMEOUT_MS        = 25.0;
   localparam real         STRETCH_BUDGET_MS = 2.0;
   localparam real         POR_READY_MS      = 500.0;
   // least times round up
   localparam int unsigned BUF_FREE_CYC  = int'($ceil(BUF_FREE_US * CLK_HZ / 1.0e6));
   localparam int unsigned HIGH_MAX_CYC  = int'($ceil(HIGH_MAX_US * CLK_HZ / 1.0e6));
   localparam int unsigned TIMEOUT_CYC   = int'($ceil(TIMEOUT_MS * CLK_HZ / 1.0e3));
   // longest times round down
   localparam int unsigned STRETCH_CYC   = int'($floor(STRETCH_BUDGET_MS * CLK_HZ / 1.0e3));
   localparam int unsigned POR_READY_CYC = int'($floor(POR_READY_MS * CLK_HZ / 1.0e3));
   localparam int unsigned POR_WAKE_CYC  = 16;     // port wakes long before the ready bound
   localparam int unsigned CNT_W         = 24;
   localparam int unsigned HOST_DIV      = 4;      // half bus period in clk cycles
   localparam int unsigned REG_COUNT     = 16;
   localparam logic [7:0]  REG_RESET     = 8'h00;
endpackage

// File: smbsel_if.sv
// management bus wires between the host and the slave
`timescale 1ns/1ps
interface smbsel_if;
   logic bus_clock_pin_o;   // host drives clock
   logic bus_clock_pin_oe;
   logic sda_host_o;        // host sda drive (low when oe)
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic chip_sel;          // host drives select
   logic bus_clock_pin;
   logic sda;
   // open drain resolution with pull-ups
   assign bus_clock_pin = bus_clock_pin_oe ? bus_clock_pin_o : 1'b1;
   assign sda = (sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o) ? 1'b0 : 1'b1;
   modport device (input bus_clock_pin, input sda, input chip_sel, output sda_dev_o, output sda_dev_oe);
   modport host (input bus_clock_pin, input sda, output bus_clock_pin_o, output bus_clock_pin_oe,
                 output sda_host_o, output sda_host_oe, output chip_sel);
endinterface

// File: smbsel_device.sv
// slave end: chip-selected byte register port on the management bus
// Behaviour
// - selected: respond, allow register reads, writes
// - deselected: ignore bus, never drive
// - host must drive chip select
// - host deselects while talking elsewhere
// - port stays alive in standby
// - answer only to address 1010110
// - data stable while clock high
// - sda fall, clock high: START
// - sda rise, clock high: STOP
// - idle after bus-free or max high
// - single byte write and read
// - clock low 25 ms: abandon, release
// - stretch total under 2 ms
// - ready within 500 ms of reset
// - write: addr, reg, data, each acked
// - read: reg, restart, addr rd, data, nack
`timescale 1ns/1ps
module smbsel_device
   import smbsel_pkg::*;
#(
   parameter int unsigned TMO_CYC = TIMEOUT_CYC      // clock-low timeout in clk cycles
)
(
   input  wire logic       clk_i,        // system clock
   input  wire logic       reset_n_i,    // sync reset, active low
   smbsel_if.device        bus,          // management bus
   input  wire logic [3:0] standby_i,    // channel standby, no effect on port
   output logic [7:0]      wr_data_o,    // last written byte
   output logic [7:0]      wr_addr_o,    // last written register
   output logic            wr_strobe_o,  // one-cycle write pulse
   output logic            idle_o,       // bus idle
   output logic            ready_o       // port ready after reset
);
   typedef enum logic [2:0] {S_WAIT, S_ADDR, S_REG, S_DATA, S_SEND, S_IGNORE} smbsel_st_type;
   typedef struct packed {
      logic [1:0]           scl_s;
      logic [1:0]           sda_s;
      logic [1:0]           cs_s;
      logic                 scl_d;
      logic                 sda_d;
      smbsel_st_type        st;
      logic [3:0]           bit_cnt;
      logic [7:0]           shift;
      logic                 rd_mode;
      logic [7:0]           reg_ptr;
      logic                 ack_phase;
      logic                 drv_low;
      logic [CNT_W-1:0]     low_cnt;
      logic [CNT_W-1:0]     high_cnt;
      logic                 stopped;
      logic                 idle;
      logic [CNT_W-1:0]     por_cnt;
      logic                 ready;
      logic [7:0]           wr_data;
      logic [7:0]           wr_addr;
      logic                 wr_stb;
      logic [REG_COUNT-1:0][7:0] regs;
   } smbsel_dev_type;
   smbsel_dev_type s_r, s_nxt;
   logic scl, sda, rise, fall, start_c, stop_c, sel;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.scl_s = {s_r.scl_s[0], bus.bus_clock_pin};
      s_nxt.sda_s = {s_r.sda_s[0], bus.sda};
      // select is a pin too, so it passes two flops before the state machine sees it
      s_nxt.cs_s = {s_r.cs_s[0], bus.chip_sel};
      scl = s_r.scl_s[1];
      sda = s_r.sda_s[1];
      s_nxt.scl_d = scl;
      s_nxt.sda_d = sda;
      sel = s_r.cs_s[1] & s_r.ready;
      rise = scl & ~s_r.scl_d;
      fall = ~scl & s_r.scl_d;
      start_c = scl & s_r.scl_d & s_r.sda_d & ~sda;
      stop_c = scl & s_r.scl_d & ~s_r.sda_d & sda;
      s_nxt.wr_stb = 1'b0;
      if (!s_r.ready)
      begin
         s_nxt.por_cnt = s_r.por_cnt + 1'b1;
         if (s_r.por_cnt >= CNT_W'(POR_WAKE_CYC - 1))
            s_nxt.ready = 1'b1;
      end
      // idle tracking
      s_nxt.low_cnt = scl ? '0 : s_r.low_cnt + ((&s_r.low_cnt) ? 1'b0 : 1'b1);
      s_nxt.high_cnt = (scl & sda) ? s_r.high_cnt + ((&s_r.high_cnt) ? 1'b0 : 1'b1) : '0;
      if (stop_c)
         s_nxt.stopped = 1'b1;
      else if (start_c)
         s_nxt.stopped = 1'b0;
      if (start_c || !(scl & sda))
         s_nxt.idle = 1'b0;
      else if ((s_r.stopped && s_r.high_cnt >= CNT_W'(BUF_FREE_CYC))
               || s_r.high_cnt >= CNT_W'(HIGH_MAX_CYC))
         s_nxt.idle = 1'b1;
      if (!sel)
      begin
         s_nxt.st = S_WAIT;
         s_nxt.drv_low = 1'b0;
      end
      else if (start_c)
      begin
         s_nxt.st = S_ADDR;
         s_nxt.bit_cnt = '0;
         s_nxt.ack_phase = 1'b0;
         s_nxt.drv_low = 1'b0;
      end
      else if (stop_c || s_r.low_cnt >= CNT_W'(TMO_CYC))
      begin
         s_nxt.st = S_WAIT;
         s_nxt.drv_low = 1'b0;
      end
      else if (s_r.st != S_WAIT && s_r.st != S_IGNORE)
      begin
         // sample on rise, change drive on fall: stable while clock high
         if (rise && !s_r.ack_phase)
         begin
            s_nxt.shift = {s_r.shift[6:0], sda};
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
         end
         if (rise && s_r.ack_phase && s_r.st == S_SEND && sda)
            s_nxt.st = S_IGNORE;
         if (fall)
         begin
            if (s_r.ack_phase)
            begin
               s_nxt.ack_phase = 1'b0;
               s_nxt.bit_cnt = '0;
               s_nxt.drv_low = 1'b0;
               if (s_r.st == S_SEND)
               begin
                  s_nxt.shift = s_r.regs[s_r.reg_ptr[3:0]];
                  s_nxt.drv_low = ~s_r.regs[s_r.reg_ptr[3:0]][7];
               end
            end
            else if (s_r.st == S_SEND && s_r.bit_cnt != 4'd8)
               s_nxt.drv_low = ~s_r.shift[7];
            else if (s_r.bit_cnt == 4'd8)
            begin
               s_nxt.ack_phase = 1'b1;
               s_nxt.drv_low = 1'b1;
               unique case (s_r.st)
                  S_ADDR:
                  begin
                     if (s_r.shift[7:1] != SLAVE_ADDR)
                     begin
                        s_nxt.st = S_IGNORE;
                        s_nxt.drv_low = 1'b0;
                        s_nxt.ack_phase = 1'b0;
                     end
                     else
                     begin
                        s_nxt.rd_mode = s_r.shift[0];
                        s_nxt.st = s_r.shift[0] ? S_SEND : S_REG;
                     end
                  end
                  S_REG:
                  begin
                     s_nxt.reg_ptr = s_r.shift;
                     s_nxt.st = S_DATA;
                  end
                  S_DATA:
                  begin
                     s_nxt.regs[s_r.reg_ptr[3:0]] = s_r.shift;
                     s_nxt.wr_data = s_r.shift;
                     s_nxt.wr_addr = s_r.reg_ptr;
                     s_nxt.wr_stb = 1'b1;
                  end
                  S_SEND:
                  begin
                     s_nxt.drv_low = 1'b0;                   // host acks or nacks
                  end
                  default:
                  begin
                     s_nxt.drv_low = 1'b0;
                  end
               endcase
            end
         end
      end
   end
   // no clock stretching is ever done, so the budget is always met
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         s_r <= '0;
         s_r.scl_s <= 2'b11;
         s_r.sda_s <= 2'b11;
         s_r.scl_d <= 1'b1;
         s_r.sda_d <= 1'b1;
         s_r.st <= S_WAIT;
         for (int i = 0; i < REG_COUNT; i++)
            s_r.regs[i] <= REG_RESET;
      end
      else
         s_r <= s_nxt;
   end
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = s_r.drv_low & bus.chip_sel;
   assign wr_data_o = s_r.wr_data;
   assign wr_addr_o = s_r.wr_addr;
   assign wr_strobe_o = s_r.wr_stb;
   assign idle_o = s_r.idle;
   assign ready_o = s_r.ready;
endmodule

// File: smbsel_host.sv
// host end: drives select and bus clock, runs single-byte write and read
`timescale 1ns/1ps
module smbsel_host
   import smbsel_pkg::*;
(
   input  wire logic       clk_i,       // system clock
   input  wire logic       reset_n_i,   // sync reset, active low
   smbsel_if.host          bus,         // management bus
   input  wire logic       req_i,       // start a transaction
   input  wire logic       rd_i,        // 1 read, 0 write
   input  wire logic [7:0] reg_i,       // register address
   input  wire logic [7:0] data_i,      // write data
   output logic            busy_o,      // transaction in progress
   output logic            done_o,      // one-cycle done pulse
   output logic            nack_o,      // some ack missing
   output logic [7:0]      rdata_o      // read data
);
   typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_DESEL} smbsel_hst_type;
   typedef struct packed {
      smbsel_hst_type st;
      logic [1:0]  sda_s;
      logic [7:0]  div;
      logic [1:0]  ph;
      logic [3:0]  bit_cnt;
      logic [1:0]  byte_idx;
      logic [7:0]  shift;
      logic        rd;
      logic        rd_phase;
      logic [7:0]  reg_a;
      logic [7:0]  wdat;
      logic        scl;
      logic        sda_low;
      logic        cs;
      logic        done;
      logic        nack;
      logic [7:0]  rdata;
   } smbsel_host_state_type;
   smbsel_host_state_type s_r, s_nxt;
   logic tick, sda;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sda_s = {s_r.sda_s[0], bus.sda};
      sda = s_r.sda_s[1];
      s_nxt.done = 1'b0;
      tick = (s_r.div == 8'(HOST_DIV - 1));
      s_nxt.div = tick ? '0 : s_r.div + 1'b1;
      unique case (s_r.st)
         H_IDLE:
         begin
            s_nxt.div = '0;
            if (req_i)
            begin
               s_nxt.cs = 1'b1;
               s_nxt.rd = rd_i;
               s_nxt.reg_a = reg_i;
               s_nxt.wdat = data_i;
               s_nxt.nack = 1'b0;
               s_nxt.rd_phase = 1'b0;
               s_nxt.ph = '0;
               s_nxt.st = H_START;
            end
         end
         H_START:
            if (tick)
            begin
               s_nxt.ph = s_r.ph + 1'b1;
               unique case (s_r.ph)
                  2'd0:
                  begin
                     s_nxt.scl = 1'b1;
                     s_nxt.sda_low = 1'b0;
                  end
                  2'd1: s_nxt.sda_low = 1'b1;
                  2'd2: s_nxt.scl = 1'b0;
                  default:
                  begin
                     s_nxt.shift = {SLAVE_ADDR, s_r.rd_phase};
                     s_nxt.byte_idx = '0;
                     s_nxt.bit_cnt = '0;
                     s_nxt.sda_low = ~SLAVE_ADDR[6];
                     s_nxt.ph = '0;
                     s_nxt.st = H_BIT;
                  end
               endcase
            end
         H_BIT:
            if (tick)
            begin
               s_nxt.scl = ~s_r.scl;
               // sample at the falling tick: the slave's drive lags our clock through its synchroniser
               if (s_r.scl)
               begin
                  if (s_r.bit_cnt == 4'd8 && sda && !(s_r.rd_phase && s_r.byte_idx == 2'd1))
                     s_nxt.nack = 1'b1;
                  if (s_r.rd_phase && s_r.byte_idx == 2'd1 && s_r.bit_cnt != 4'd8)
                     s_nxt.rdata = {s_r.rdata[6:0], sda};
                  s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
                  s_nxt.shift = {s_r.shift[6:0], 1'b0};
                  if (s_r.bit_cnt == 4'd7)
                     s_nxt.sda_low = 1'b0;                     // release for the ack or nack
                  else if (s_r.bit_cnt == 4'd8)
                  begin
                     s_nxt.bit_cnt = '0;
                     s_nxt.byte_idx = s_r.byte_idx + 1'b1;
                     if (s_r.rd_phase ? s_r.byte_idx == 2'd1 : (!s_r.rd && s_r.byte_idx == 2'd2))
                     begin
                        s_nxt.sda_low = 1'b1;
                        s_nxt.ph = '0;
                        s_nxt.st = H_STOP;
                     end
                     else if (s_r.rd && !s_r.rd_phase && s_r.byte_idx == 2'd1)
                     begin
                        s_nxt.rd_phase = 1'b1;
                        s_nxt.sda_low = 1'b0;
                        s_nxt.ph = '0;
                        s_nxt.st = H_START;
                     end
                     else
                     begin
                        s_nxt.shift = s_r.byte_idx == 2'd0 ? s_r.reg_a : s_r.wdat;
                        s_nxt.sda_low = s_r.rd_phase ? 1'b0
                                       : ~(s_r.byte_idx == 2'd0 ? s_r.reg_a[7] : s_r.wdat[7]);
                     end
                  end
                  else
                     s_nxt.sda_low = s_r.rd_phase && s_r.byte_idx == 2'd1 ? 1'b0 : ~s_r.shift[6];
               end
            end
         H_STOP:
            if (tick)
            begin
               s_nxt.ph = s_r.ph + 1'b1;
               if (s_r.ph == 2'd0)
                  s_nxt.scl = 1'b1;
               else if (s_r.ph == 2'd1)
                  s_nxt.sda_low = 1'b0;
               else
                  s_nxt.st = H_DESEL;
            end
         H_DESEL:
         begin
            s_nxt.cs = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st = H_IDLE;
         end
         default:
            s_nxt.st = H_IDLE;
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         s_r <= '0;
         s_r.st <= H_IDLE;
         s_r.scl <= 1'b1;
         s_r.sda_s <= 2'b11;
      end
      else
         s_r <= s_nxt;
   end
   assign bus.bus_clock_pin_o = 1'b0;
   assign bus.bus_clock_pin_oe = ~s_r.scl;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = s_r.sda_low;
   assign bus.chip_sel = s_r.cs;
   assign busy_o = (s_r.st != H_IDLE);
   assign done_o = s_r.done;
   assign nack_o = s_r.nack;
   assign rdata_o = s_r.rdata;
endmodule

// File: smbsel_sva.sv
// bus-level checker for the chip-selected slave
`timescale 1ns/1ps
module smbsel_sva
   import smbsel_pkg::*;
(
   input wire logic clk_i,         // clock
   input wire logic reset_n_i,     // sync reset
   input wire logic bus_clock_pin, // bus clock
   input wire logic sda,           // data line
   input wire logic chip_sel,      // select
   input wire logic sda_dev_o,     // slave drive
   input wire logic sda_dev_oe     // slave enable
);
   logic        scl_q_r, sda_q_r, hit_r, rd_r, miss_r;
   logic [3:0]  cnt_r;
   logic [1:0]  byte_r;
   logic [7:0]  sh_r;
   logic [23:0] low_r;
   wire logic   start_w = bus_clock_pin & scl_q_r & sda_q_r & ~sda;
   wire logic   stop_w  = bus_clock_pin & scl_q_r & ~sda_q_r & sda;
   wire logic   rise_w  = bus_clock_pin & ~scl_q_r;
   wire logic   ninth_w = rise_w & (cnt_r == 4'h8);
   wire logic   match_w = (sh_r[7:1] == SLAVE_ADDR);
   wire logic   dlow_w  = sda_dev_oe & ~sda_dev_o;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         {hit_r, rd_r, miss_r, cnt_r, byte_r, sh_r, low_r} <= '0;
      end
      else
      begin
         scl_q_r <= bus_clock_pin;
         sda_q_r <= sda;
         low_r   <= bus_clock_pin ? 24'h000000 : low_r + 24'h000001;
         if (start_w)
            {hit_r, miss_r, cnt_r, byte_r} <= '0;
         else if (stop_w)
            {hit_r, miss_r} <= '0;
         else if (rise_w)
         begin
            sh_r  <= {sh_r[6:0], sda};
            cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
            if (ninth_w && byte_r != 2'h3)
               byte_r <= byte_r + 2'h1;
            // only the first byte after a start carries the address
            if (ninth_w && byte_r == 2'h0)
            begin
               hit_r  <= chip_sel & match_w;
               miss_r <= chip_sel & ~match_w;
               rd_r   <= sh_r[0];
            end
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_ack_slot;
      ninth_w && chip_sel;
   endsequence

   a_desel_quiet: assert property ((!chip_sel)[*3] |-> !sda_dev_oe)
      else $error("slave drives data while deselected");
   a_addr_ack: assert property (s_ack_slot ##0 (byte_r == 2'h0 && match_w) |-> !sda)
      else $error("own address not acknowledged");
   a_data_ack: assert property (s_ack_slot ##0 (hit_r && !rd_r && byte_r != 2'h0) |-> !sda)
      else $error("write byte not acknowledged");
   a_read_release: assert property (s_ack_slot ##0 (hit_r && rd_r && byte_r != 2'h0) |-> !dlow_w)
      else $error("slave holds data during host nack");
   a_miss_quiet: assert property (miss_r |-> !sda_dev_oe)
      else $error("slave drives after foreign address");
   a_hold_high: assert property ($changed(dlow_w) |-> !bus_clock_pin)
      else $error("slave data changed while clock high");
   a_stop_release: assert property (stop_w |=> (!sda_dev_oe)[*8])
      else $error("slave drives after stop");
   a_start_quiet: assert property (start_w |=> (!dlow_w)[*8])
      else $error("slave drives during address reception");
   a_timeout_free: assert property ((low_r > 24'(TIMEOUT_CYC + 8)) |-> !sda_dev_oe)
      else $error("slave holds bus after clock low timeout");
endmodule

// File: smbus_slave_with_select_test.sv
// self-checking bench: host and slave face to face, plus a faulted second bus
`timescale 1ns/1ps
module smbus_slave_with_select_test;
   import smbsel_pkg::*;
   logic       clk_i = 1'b0, reset_n_i = 1'b0, req_i = 1'b0, rd_i = 1'b0, scl_q = 1'b1, sda_q = 1'b1, ak;
   logic [7:0] reg_i = 8'h00, data_i = 8'h00, wr_data_o, wr_addr_o, rdata_o, wd2, wa2, r1, d1;
   logic [3:0] standby_i = 4'h0;
   logic       busy_o, done_o, nack_o, wr_strobe_o, idle_o, ready_o, st2, rdy2;
   int         err_count = 0, num_checks = 0, seed = 88449, stb = 0, stb2 = 0, wr_n = 0, sts = 0, sps = 0, cnt;
   int         model [16];
   // short timeout on the faulted slave keeps the stall test inside the run budget
   localparam int unsigned TEST_TMO_CYC = 2000;
   smbsel_if bus ();
   smbsel_if bus2 ();

   always #20 clk_i = ~clk_i;

   smbsel_host smbsel_host_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus), .req_i(req_i), .rd_i(rd_i),
      .reg_i(reg_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
   smbsel_device smbsel_device_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(bus), .standby_i(standby_i),
      .wr_data_o(wr_data_o), .wr_addr_o(wr_addr_o), .wr_strobe_o(wr_strobe_o), .idle_o(idle_o), .ready_o(ready_o));
   // second slave faces the bench's rule-breaking driver
   smbsel_device #(.TMO_CYC(TEST_TMO_CYC)) smbsel_device_fault_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .bus(bus2), .standby_i(standby_i), .wr_data_o(wd2), .wr_addr_o(wa2), .wr_strobe_o(st2), .idle_o(),
      .ready_o(rdy2));
   smbsel_sva smbsel_sva_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_clock_pin(bus.bus_clock_pin),
      .sda(bus.sda), .chip_sel(bus.chip_sel), .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe));

   always @(posedge clk_i)
   begin
      if (wr_strobe_o === 1'b1)
         stb++;
      if (st2 === 1'b1)
         stb2++;
      if (bus.bus_clock_pin && scl_q && sda_q && !bus.sda)
         sts++;
      if (bus.bus_clock_pin && scl_q && !sda_q && bus.sda)
         sps++;
      scl_q <= bus.bus_clock_pin;
      sda_q <= bus.sda;
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic xfer(input logic rd, input logic [7:0] ra, input logic [7:0] wd);
      int n, s0, p0;
      n = 0;
      s0 = sts;
      p0 = sps;
      @(posedge clk_i) #1 req_i = 1'b1;
      rd_i = rd;
      reg_i = ra;
      data_i = wd;
      standby_i = 4'($random(seed));
      @(posedge clk_i) #1 req_i = 1'b0;
      repeat (20) @(negedge clk_i);
      check("idle_o busy", 8'h00, 8'(idle_o));
      while (done_o !== 1'b1 && n < 5000)
      begin
         @(negedge clk_i);
         n++;
      end
      check("done_o", 8'h01, 8'(done_o));
      check("nack_o", 8'h00, 8'(nack_o));
      check("starts", rd ? 8'h02 : 8'h01, 8'(sts - s0));
      check("stops", 8'h01, 8'(sps - p0));
      // bus free time counts from the stop, which lies before done
      repeat (BUF_FREE_CYC + 10) @(negedge clk_i);
      check("idle_o", 8'h01, 8'(idle_o));
      if (rd)
         check("rdata_o", 8'(model[ra[3:0]]), rdata_o);
      else
      begin
         model[ra[3:0]] = wd;
         wr_n++;
         check("wr_data_o", wd, wr_data_o);
         check("wr_addr_o", ra, wr_addr_o);
         check("strobes", 8'(wr_n), 8'(stb));
      end
   endtask

   // clock moves first, data one cycle later, so no false start or stop
   task automatic put(input logic c, input logic d);
      @(posedge clk_i) #1 bus2.bus_clock_pin_oe = ~c;
      @(posedge clk_i) #1 bus2.sda_host_oe = ~d;
      repeat (3) @(posedge clk_i);
   endtask

   task automatic send(input logic [7:0] b, output logic a);
      for (int i = 7; i >= 0; i--)
      begin
         put(1'b0, b[i]);
         put(1'b1, b[i]);
      end
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
      a = bus2.sda;
   endtask

   task automatic start();
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
      put(1'b1, 1'b0);
   endtask

   task automatic stop();
      put(1'b0, 1'b0);
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
   endtask

   task automatic frame(input logic cs, input logic [7:0] a0, output logic a);
      logic x;
      #1 bus2.chip_sel = cs;
      start();
      send(a0, a);
      send(8'($random(seed)), x);
      send(8'($random(seed)), x);
      stop();
   endtask

   initial
   begin
      foreach (model[i])
         model[i] = REG_RESET;
      bus2.bus_clock_pin_o = 1'b0;
      bus2.bus_clock_pin_oe = 1'b0;
      bus2.sda_host_o = 1'b0;
      bus2.sda_host_oe = 1'b0;
      bus2.chip_sel = 1'b0;
      repeat (12) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      cnt = 0;
      while (!(ready_o === 1'b1 && rdy2 === 1'b1))
      begin
         @(negedge clk_i);
         cnt++;
      end
      check("ready time", 8'h01, 8'(cnt <= POR_READY_CYC + 4));
      // no stop seen yet: only the long clock-high limit may declare idle
      repeat (BUF_FREE_CYC + 10) @(negedge clk_i);
      check("idle_o no stop", 8'h00, 8'(idle_o));
      repeat (HIGH_MAX_CYC - BUF_FREE_CYC) @(negedge clk_i);
      check("idle_o max high", 8'h01, 8'(idle_o));
      for (int i = 0; i < 24; i++)
         xfer(1'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      for (int r = 0; r < 16; r++)
         xfer(1'b1, 8'(r), 8'h00);
      frame(1'b0, ADDR_BYTE_WR, ak);
      check("ack deselected", 8'h01, 8'(ak));
      for (int k = 0; k < 7; k++)
      begin
         frame(1'b1, {SLAVE_ADDR ^ (7'h01 << k), 1'b0}, ak);
         check("ack foreign", 8'h01, 8'(ak));
      end
      check("strobes fault", 8'h00, 8'(stb2));
      r1 = 8'($random(seed));
      d1 = 8'($random(seed));
      start();
      send(ADDR_BYTE_WR, ak);
      send(8'h03, ak);
      start();
      send(ADDR_BYTE_WR, ak);
      check("ack restart", 8'h00, 8'(ak));
      send(r1, ak);
      send(d1, ak);
      stop();
      check("strobes restart", 8'h01, 8'(stb2));
      check("data restart", d1, wd2);
      check("reg restart", r1, wa2);
      start();
      for (int i = 7; i >= 0; i--)
      begin
         put(1'b0, ADDR_BYTE_WR[i]);
         put(1'b1, ADDR_BYTE_WR[i]);
      end
      // stall inside the ack slot, while the slave pulls data low
      put(1'b0, 1'b1);
      check("ack before stall", 8'h00, 8'(bus2.sda));
      repeat (TEST_TMO_CYC + 100) @(posedge clk_i);
      check("sda after stall", 8'h01, 8'(bus2.sda));
      send(r1, ak);
      check("ack after stall", 8'h01, 8'(ak));
      send(d1, ak);
      stop();
      check("strobes stall", 8'h01, 8'(stb2));
      complete_run();
   end

   initial
   begin
      // 1000 cycles per bus transfer, over twice the under-500 a read takes, the fault frames and the stall on top
      repeat (40 * 1000 + 10 * 1000 + TEST_TMO_CYC + HIGH_MAX_CYC) @(posedge clk_i);
      err_count++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      complete_run();
   end
endmodule
